// ==== shared/cprc_cfg.svh ====
// Constants for the configuration port persistence controller
`ifndef CPRC_CFG_SVH
`define CPRC_CFG_SVH
`define CPRC_I2C_ADDR_W 10
`define CPRC_I2C_ADDR_ERASED 10'h3C0
`define CPRC_I2C_ADDR_RSVD 10'h3C1
`define CPRC_ALTER_MAX 4'h8
`define CPRC_ROW_W 15
// Feature row bit positions
`define CPRC_B_PROG 0
`define CPRC_B_INIT 1
`define CPRC_B_DONE 2
`define CPRC_B_SCAN 3
`define CPRC_B_SLAVE_SERIAL_CFG_PORT 4
`define CPRC_B_I2C 5
`define CPRC_B_MASTER_SERIAL_CFG_PORT 6
// Eight user address bits: three upper and five lower selectable bits
`define CPRC_B_ADDR_LO 7
`define CPRC_B_ADDR_HI 14
// Erased row: scan, slave_serial_cfg_port, i2c, program request on; address field zero
`define CPRC_ROW_ERASED 15'h0039
`endif

// ==== shared/cprc_pkg.sv ====
// Types for the configuration port persistence controller
package cprc_pkg;
	typedef enum logic [1:0] {
		CPRC_ST_INIT = 2'b00,
		CPRC_ST_CONFIG = 2'b01,
		CPRC_ST_USER = 2'b10
	} cprc_state_t;
endpackage

// ==== rtl/cprc_row_store.sv ====
// Feature row storage with lifetime alteration counter
`timescale 1ns/1ps
`include "cprc_cfg.svh"
module cprc_row_store
	import cprc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic erase_req,
	input wire logic write_req,
	input wire logic [`CPRC_ROW_W-1:0] write_data,
	output logic [`CPRC_ROW_W-1:0] row_data,
	output logic row_erased,
	output logic alter_exhausted
);
	logic [`CPRC_ROW_W-1:0] row_r, row_nxt;
	logic erased_r, erased_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic can_alter;

	// Each accepted erase or write spends one lifetime alteration; requests after the limit are ignored
	always_comb begin
		can_alter = (cnt_r != `CPRC_ALTER_MAX);
		row_nxt = row_r;
		erased_nxt = erased_r;
		cnt_nxt = cnt_r;
		if (can_alter && erase_req) begin
			row_nxt = `CPRC_ROW_ERASED;
			erased_nxt = 1'b1;
			cnt_nxt = cnt_r + 4'h1;
		end else if (can_alter && write_req) begin
			row_nxt = write_data;
			erased_nxt = 1'b0;
			cnt_nxt = cnt_r + 4'h1;
		end
	end

	// Reset models a blank part: row erased, no alterations used
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			row_r <= `CPRC_ROW_ERASED;
			erased_r <= 1'b1;
			cnt_r <= 4'h0;
		end else begin
			row_r <= row_nxt;
			erased_r <= erased_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign row_data = row_r;
	assign row_erased = erased_r;
	assign alter_exhausted = ~can_alter;

	property p_cnt_cap;
		@(posedge clock) disable iff (sys_rst) cnt_r <= `CPRC_ALTER_MAX;
	endproperty
	a_cnt_cap: assert property (p_cnt_cap) else $error("alteration count over limit");

	// Once the budget is spent the stored row must never move again
	property p_frozen;
		@(posedge clock) disable iff (sys_rst)
		alter_exhausted |=> $stable(row_data) && $stable(row_erased);
	endproperty
	a_frozen: assert property (p_frozen) else $error("row altered after limit");
endmodule

// ==== rtl/cprc_top.sv ====
// Configuration port persistence controller: pin role decode
//
// Behaviour
// - An erased feature row always makes the program request pin a configuration input.
// - The I2C address is 1111000000 when erased, 1111000001 is reserved, else yyyxxxxx00.
// - Program request, init status and done pins are each enabled by their row bit.
// - An erased row enables the scan, slave serial and I2C ports.
// - On user mode entry slave serial and I2C go to user I/O unless a programmed row enables them.
// - Pins of a disabled port group become user I/O, else stay for programming.
// - Erased and programmed defaults differ only for slave serial and I2C.
// - The feature row may be altered at most eight times in total.
// - Each configuration memory update rewrites the feature row with the supplied contents, without an erase.
// - Erasing the row restores every setting to its erased default.
// - An enabled program request falling edge leaves user mode and restarts init.
`timescale 1ns/1ps
`include "cprc_cfg.svh"
module cprc_top
	import cprc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic program_request_pin,
	input wire logic scan_port_enable_pin,
	input wire logic row_erase,
	input wire logic row_write,
	input wire logic [`CPRC_ROW_W-1:0] row_write_data,
	input wire logic mem_update,
	input wire logic config_done,
	output logic user_mode,
	output logic cfg_restart,
	output logic prog_pin_cfg,
	output logic init_status_pin_cfg,
	output logic done_pin_cfg,
	output logic scan_port_cfg,
	output logic slave_serial_cfg_port_cfg,
	output logic i2c_port_cfg,
	output logic master_serial_cfg_port_cfg,
	output logic [`CPRC_I2C_ADDR_W-1:0] i2c_cfg_addr,
	output logic [`CPRC_I2C_ADDR_W-1:0] i2c_rsvd_addr,
	output logic i2c_rsvd_valid,
	output logic row_erased,
	output logic alter_exhausted
);
	////////////////////////////////////////////////////////////////////////
	logic [`CPRC_ROW_W-1:0] row;
	logic erase_any, write_any;

	// A memory update rewrites the row with the supplied contents
	assign erase_any = row_erase | mem_update;
	assign write_any = row_write | mem_update;

	cprc_row_store u_store (
		.clock(clock),
		.sys_rst(sys_rst),
		.erase_req(erase_any & ~mem_update),
		.write_req(write_any),
		.write_data(row_write_data),
		.row_data(row),
		.row_erased(row_erased),
		.alter_exhausted(alter_exhausted)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage one feeds only stage two
	logic prog_s1_r, prog_s2_r, prog_s3_r;
	logic scan_s1_r, scan_s2_r;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prog_s1_r <= 1'b1;
			prog_s2_r <= 1'b1;
			prog_s3_r <= 1'b1;
			scan_s1_r <= 1'b1;
			scan_s2_r <= 1'b1;
		end else begin
			prog_s1_r <= program_request_pin;
			prog_s2_r <= prog_s1_r;
			prog_s3_r <= prog_s2_r;
			scan_s1_r <= scan_port_enable_pin;
			scan_s2_r <= scan_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Persistence decode; erased row forces hardware defaults
	logic prog_en, init_en, done_en, scan_en, slave_serial_cfg_port_en, i2c_en, master_serial_cfg_port_en;

	always_comb begin
		prog_en = row_erased | row[`CPRC_B_PROG];
		init_en = ~row_erased & row[`CPRC_B_INIT];
		done_en = ~row_erased & row[`CPRC_B_DONE];
		scan_en = row_erased | row[`CPRC_B_SCAN];
		slave_serial_cfg_port_en = row_erased | row[`CPRC_B_SLAVE_SERIAL_CFG_PORT];
		i2c_en = row_erased | row[`CPRC_B_I2C];
		master_serial_cfg_port_en = ~row_erased & row[`CPRC_B_MASTER_SERIAL_CFG_PORT];
	end

	////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	cprc_state_t state_r, state_nxt;
	logic prog_fall;

	// Held low keeps the sequencer in init while the request pin is enabled, as the pin requires
	assign prog_fall = prog_en & prog_s3_r & ~prog_s2_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CPRC_ST_INIT: begin
				if (prog_s2_r | ~prog_en) begin
					state_nxt = CPRC_ST_CONFIG;
				end
			end
			CPRC_ST_CONFIG: begin
				if (prog_fall) begin
					state_nxt = CPRC_ST_INIT;
				end else if (config_done) begin
					state_nxt = CPRC_ST_USER;
				end
			end
			CPRC_ST_USER: begin
				if (prog_fall) begin
					state_nxt = CPRC_ST_INIT;
				end
			end
			default: begin
				state_nxt = CPRC_ST_INIT;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= CPRC_ST_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin role selection, refreshed every cycle
	logic user_r, user_nxt, restart_r, restart_nxt;
	logic [6:0] role_r, role_nxt;
	logic [`CPRC_I2C_ADDR_W-1:0] addr_r, addr_nxt;

	always_comb begin
		user_nxt = (state_nxt == CPRC_ST_USER);
		restart_nxt = prog_fall & (state_r != CPRC_ST_INIT);
		// In config mode an erased row keeps request, slave serial and I2C for programming, scan if its pin is high
		role_nxt[0] = prog_en;
		role_nxt[1] = init_en;
		role_nxt[2] = done_en;
		role_nxt[3] = scan_en & scan_s2_r;
		// User mode drops serial ports unless the row keeps them
		role_nxt[4] = user_nxt ? (~row_erased & slave_serial_cfg_port_en) : slave_serial_cfg_port_en;
		role_nxt[5] = user_nxt ? (~row_erased & i2c_en) : i2c_en;
		role_nxt[6] = master_serial_cfg_port_en;
		if (row_erased) begin
			addr_nxt = `CPRC_I2C_ADDR_ERASED;
		end else begin
			// All eight selectable bits come from the row, two low bits fixed
			addr_nxt = {row[`CPRC_B_ADDR_HI:`CPRC_B_ADDR_LO], 2'b00};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			user_r <= 1'b0;
			restart_r <= 1'b0;
			role_r <= 7'h39;
			addr_r <= `CPRC_I2C_ADDR_ERASED;
		end else begin
			user_r <= user_nxt;
			restart_r <= restart_nxt;
			role_r <= role_nxt;
			addr_r <= addr_nxt;
		end
	end

	assign user_mode = user_r;
	assign cfg_restart = restart_r;
	assign prog_pin_cfg = role_r[0];
	assign init_status_pin_cfg = role_r[1];
	assign done_pin_cfg = role_r[2];
	assign scan_port_cfg = role_r[3];
	assign slave_serial_cfg_port_cfg = role_r[4];
	assign i2c_port_cfg = role_r[5];
	assign master_serial_cfg_port_cfg = role_r[6];
	assign i2c_cfg_addr = addr_r;
	assign i2c_rsvd_addr = `CPRC_I2C_ADDR_RSVD;
	assign i2c_rsvd_valid = row_erased;

	////////////////////////////////////////////////////////////////////////
	sequence s_fall_seen;
		prog_fall && state_r != CPRC_ST_INIT;
	endsequence

	property p_erased_prog;
		@(posedge clock) disable iff (sys_rst) row_erased |=> prog_pin_cfg || $past(sys_rst);
	endproperty
	a_erased_prog: assert property (p_erased_prog) else $error("erased row lost request pin");

	property p_addr;
		@(posedge clock) disable iff (sys_rst)
		row_erased ##1 row_erased |-> i2c_cfg_addr == `CPRC_I2C_ADDR_ERASED;
	endproperty
	a_addr: assert property (p_addr) else $error("wrong erased address");

	property p_addr_low;
		@(posedge clock) disable iff (sys_rst) !row_erased ##1 !row_erased |-> i2c_cfg_addr[1:0] == 2'b00;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("programmed address low bits set");

	property p_erased_ports;
		@(posedge clock) disable iff (sys_rst)
		(row_erased && state_r != CPRC_ST_USER) [*2] |-> slave_serial_cfg_port_cfg && i2c_port_cfg;
	endproperty
	a_erased_ports: assert property (p_erased_ports) else $error("erased ports not enabled");

	property p_user_drop;
		@(posedge clock) disable iff (sys_rst)
		$past(row_erased) && row_erased && $rose(user_mode) |->
			!i2c_port_cfg && !slave_serial_cfg_port_cfg;
	endproperty
	a_user_drop: assert property (p_user_drop) else $error("serial ports kept in user mode");

	property p_init_off;
		@(posedge clock) disable iff (sys_rst) row_erased [*2] |-> !init_status_pin_cfg && !done_pin_cfg;
	endproperty
	a_init_off: assert property (p_init_off) else $error("status pins enabled when erased");

	property p_master_serial_cfg_port;
		@(posedge clock) disable iff (sys_rst) row_erased [*2] |-> !master_serial_cfg_port_cfg;
	endproperty
	a_master_serial_cfg_port: assert property (p_master_serial_cfg_port) else $error("master serial on when erased");

	property p_restart;
		@(posedge clock) disable iff (sys_rst)
		s_fall_seen |=> cfg_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart pulse on request");

	property p_leave_user;
		@(posedge clock) disable iff (sys_rst) prog_fall |=> !user_mode && state_r == CPRC_ST_INIT;
	endproperty
	a_leave_user: assert property (p_leave_user) else $error("request edge did not restart");

	property p_scan_follow;
		@(posedge clock) disable iff (sys_rst) row_erased && !scan_s2_r |=> !scan_port_cfg;
	endproperty
	a_scan_follow: assert property (p_scan_follow) else $error("scan port ignores enable");
endmodule

// ==== bench/cprc_host_model.sv ====
// Board-side host model driving the shared request and scan enable pins
`timescale 1ns/1ps
module cprc_host_model (
	input wire logic clock,
	output logic program_request_pin,
	output logic scan_port_enable_pin
);
	// Weak pull-up idle level on the request pin; scan port left enabled
	initial begin
		program_request_pin = 1'b1;
		scan_port_enable_pin = 1'b1;
	end
	// Short low pulse only; a held-low pin would stall an erased row forever
	task automatic req_pulse(input int cyc);
		@(negedge clock);
		program_request_pin = 1'b0;
		repeat (cyc) @(negedge clock);
		program_request_pin = 1'b1;
	endtask
	// Scan enable moved while this host keeps off the scan pins
	task automatic scan_en(input logic v);
		@(negedge clock);
		scan_port_enable_pin = v;
	endtask
endmodule

// ==== bench/config_port_persistence_ctrl_bench.sv ====
// Self-checking testbench for the configuration port persistence controller
`timescale 1ns/1ps
`include "cprc_cfg.svh"
module config_port_persistence_ctrl_bench;
	import cprc_pkg::*;
	logic clock, sys_rst, row_erase, row_write, mem_update, config_done;
	logic [14:0] row_write_data;
	wire logic prq, sen, user_mode, cfg_restart, rsvd_ok, erased, exhausted;
	wire logic prog, init, done, scan, slave_serial_cfg_port, i2c, master_serial_cfg_port;
	wire logic [9:0] addr, rsvd;
	wire logic [9:0] roles;
	int error_cnt = 0;
	int checks = 0;
	// Roles packed in row bit order so a programmed row maps straight across
	assign roles = {3'b000, master_serial_cfg_port, i2c, slave_serial_cfg_port, scan, done, init, prog};
	cprc_host_model cprc_host_model_i (.clock(clock), .program_request_pin(prq),
		.scan_port_enable_pin(sen));
	cprc_top cprc_top_i (.clock(clock), .sys_rst(sys_rst), .program_request_pin(prq),
		.scan_port_enable_pin(sen), .row_erase(row_erase), .row_write(row_write),
		.row_write_data(row_write_data), .mem_update(mem_update),
		.config_done(config_done), .user_mode(user_mode), .cfg_restart(cfg_restart),
		.prog_pin_cfg(prog), .init_status_pin_cfg(init), .done_pin_cfg(done),
		.scan_port_cfg(scan), .slave_serial_cfg_port_cfg(slave_serial_cfg_port), .i2c_port_cfg(i2c),
		.master_serial_cfg_port_cfg(master_serial_cfg_port), .i2c_cfg_addr(addr), .i2c_rsvd_addr(rsvd),
		.i2c_rsvd_valid(rsvd_ok), .row_erased(erased), .alter_exhausted(exhausted));
	////////////////////////////////////////////////////////////////
	// Clock generator from time zero
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	// Compare helpers and closing
	task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Row alteration pulse, then time for roles to settle
	task automatic alter(input logic [2:0] k, input logic [14:0] d);
		@(negedge clock);
		{row_erase, row_write, mem_update} = k;
		row_write_data = d;
		@(negedge clock);
		{row_erase, row_write, mem_update} = 3'b000;
		repeat (4) @(negedge clock);
	endtask
	// Load finished; hold done until the state machine takes it
	task automatic to_user();
		int n;
		n = 0;
		@(negedge clock);
		config_done = 1'b1;
		while (user_mode !== 1'b1 && n < 10) begin
			@(negedge clock);
			n++;
		end
		config_done = 1'b0;
		repeat (3) @(negedge clock);
		chk_bit(user_mode, 1'b1, "user mode not entered");
	endtask
	// Request pulse; report whether a restart pulse came out
	task automatic request(output logic seen);
		seen = 1'b0;
		fork
			cprc_host_model_i.req_pulse(3);
			repeat (12) begin
				@(negedge clock);
				if (cfg_restart === 1'b1) seen = 1'b1;
			end
		join
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_erased();
		chk_vec(roles, 10'h039, "erased roles");
		chk_vec(addr, 10'h3C0, "erased i2c address");
		chk_vec(rsvd, 10'h3C1, "reserved address");
		chk_bit(rsvd_ok, 1'b1, "reserved flag");
		cprc_host_model_i.scan_en(1'b0);
		repeat (5) @(negedge clock);
		chk_bit(scan, 1'b0, "scan role with enable low");
		cprc_host_model_i.scan_en(1'b1);
		repeat (5) @(negedge clock);
		chk_bit(scan, 1'b1, "scan role with enable high");
	endtask
	task automatic t_restart();
		logic seen;
		to_user();
		chk_vec(roles, 10'h009, "user roles, erased row");
		request(seen);
		chk_bit(seen, 1'b1, "no restart pulse");
		chk_bit(user_mode, 1'b0, "user mode kept after request");
		to_user();
	endtask
	task automatic t_programmed();
		logic seen;
		alter(3'b010, 15'h5A6C);
		chk_vec(roles, 10'h06C, "row A roles");
		chk_vec(addr, 10'h2D0, "row A address");
		chk_bit(rsvd_ok, 1'b0, "reserved flag programmed");
		request(seen);
		chk_bit(seen, 1'b0, "restart with request disabled");
		chk_bit(user_mode, 1'b1, "user mode lost");
		alter(3'b010, 15'h7F97);
		chk_vec(roles, 10'h017, "row B roles");
		chk_vec(addr, 10'h3FC, "row B address");
		alter(3'b100, 15'h0000);
		chk_vec(roles, 10'h009, "erased again roles");
		chk_vec(addr, 10'h3C0, "erased again address");
		chk_bit(erased, 1'b1, "erase flag");
	endtask
	task automatic t_exhaust();
		alter(3'b001, 15'h0097);
		chk_vec(addr, 10'h004, "update address");
		chk_bit(exhausted, 1'b0, "exhausted too early");
		repeat (4) alter(3'b010, 15'h0097);
		chk_bit(exhausted, 1'b1, "not exhausted after eight");
		alter(3'b100, 15'h0000);
		chk_bit(erased, 1'b0, "ninth alteration taken");
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		sys_rst = 1'b1;
		{row_erase, row_write, mem_update, config_done} = 4'h0;
		row_write_data = 15'h0000;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		repeat (6) @(negedge clock);
		t_erased();
		t_restart();
		t_programmed();
		t_exhaust();
		final_report();
	end
	initial begin
		#(40 * 3000);
		error_cnt++;
		final_report();
	end
endmodule
